//--- hw/uemr_pkg.sv
// shared constants and types of the endpoint mode responder
package uemr_pkg;
  // endpoint mode encodings
  localparam logic [3:0] UEMR_M_DIS          = 4'h0;
  localparam logic [3:0] UEMR_M_NAK_IO       = 4'h1;
  localparam logic [3:0] UEMR_M_STAT_OUT     = 4'h2;
  localparam logic [3:0] UEMR_M_STALL_IO     = 4'h3;
  localparam logic [3:0] UEMR_M_IGN_IO       = 4'h4;
  localparam logic [3:0] UEMR_M_RSV5         = 4'h5;
  localparam logic [3:0] UEMR_M_STAT_IN      = 4'h6;
  localparam logic [3:0] UEMR_M_RSV7         = 4'h7;
  localparam logic [3:0] UEMR_M_NAK_OUT      = 4'h8;
  localparam logic [3:0] UEMR_M_ACK_OUT      = 4'h9;
  localparam logic [3:0] UEMR_M_NAKOUT_STIN  = 4'hA;
  localparam logic [3:0] UEMR_M_ACKOUT_NAKIN = 4'hB;
  localparam logic [3:0] UEMR_M_NAK_IN       = 4'hC;
  localparam logic [3:0] UEMR_M_ACK_IN       = 4'hD;
  localparam logic [3:0] UEMR_M_NAKIN_STOUT  = 4'hE;
  localparam logic [3:0] UEMR_M_ACKIN_STOUT  = 4'hF;
  // token identifiers
  localparam logic [1:0] UEMR_PID_OUT   = 2'h0;
  localparam logic [1:0] UEMR_PID_IN    = 2'h1;
  localparam logic [1:0] UEMR_PID_SETUP = 2'h2;
  // status check: zero data bytes plus two crc bytes, toggle one
  localparam logic [4:0] UEMR_CHK_CNT = 5'h02;
  localparam logic       UEMR_CHK_TOG = 1'b1;
  localparam logic [4:0] UEMR_CRC_LEN = 5'h02;
  // register map (byte addresses)
  localparam logic [7:0] UEMR_MODE_BASE = 8'h00;
  localparam logic [7:0] UEMR_CNT_BASE  = 8'h10;
  localparam int         UEMR_REGION_BIT = 4;
  // mode register fields
  localparam int UEMR_MODE_LSB  = 0;
  localparam int UEMR_F_ACK     = 4;
  localparam int UEMR_F_OUT     = 5;
  localparam int UEMR_F_IN      = 6;
  localparam int UEMR_F_SETUP   = 7;
  localparam int UEMR_F_STALL   = 7;
  // count register fields
  localparam int UEMR_F_DVAL    = 6;
  localparam int UEMR_F_TOG     = 7;
  localparam int UEMR_DEF_EP_SIZE = 8;
  localparam int UEMR_DEF_NUM_EP  = 3;

  typedef enum logic [2:0] {
    UEMR_IN_IGN, UEMR_IN_NAK, UEMR_IN_STALL, UEMR_IN_TX0, UEMR_IN_TXC
  } uemr_in_act_t;
  typedef enum logic [2:0] {
    UEMR_OUT_IGN, UEMR_OUT_NAK, UEMR_OUT_STALL, UEMR_OUT_ACK, UEMR_OUT_CHK
  } uemr_out_act_t;
  typedef enum logic [2:0] {
    UEMR_R_NONE, UEMR_R_ACK, UEMR_R_NAK, UEMR_R_STALL, UEMR_R_DATA
  } uemr_resp_t;
endpackage

//--- hw/uemr_dec_if.sv
// mode decode carrier between engine and decoder
`timescale 1ns/1ps
`default_nettype none
interface uemr_dec_if;
  logic                    [3:0] mode;
  logic                          stall_sel;
  logic                          setup_ok;
  uemr_pkg::uemr_in_act_t        in_act;
  uemr_pkg::uemr_out_act_t       out_act;
  logic                    [3:0] in_nx;
  logic                    [3:0] out_nx;
  modport dec (input mode, input stall_sel, output setup_ok,
               output in_act, output out_act, output in_nx, output out_nx);
  modport eng (output mode, output stall_sel, input setup_ok,
               input in_act, input out_act, input in_nx, input out_nx);
endinterface
`default_nettype wire

//--- hw/uemr_mode_dec.sv
// decodes an endpoint mode into its token answers
`timescale 1ns/1ps
`default_nettype none
module uemr_mode_dec (
  uemr_dec_if.dec d
);
  always_comb begin
    d.setup_ok = 1'b0;
    d.in_act   = uemr_pkg::UEMR_IN_IGN;
    d.out_act  = uemr_pkg::UEMR_OUT_IGN;
    d.in_nx    = d.mode;
    d.out_nx   = d.mode;
    case (d.mode)
      uemr_pkg::UEMR_M_NAK_IO: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_NAK;
        d.out_act  = uemr_pkg::UEMR_OUT_NAK;
      end
      uemr_pkg::UEMR_M_STAT_OUT: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_STALL;
        d.out_act  = uemr_pkg::UEMR_OUT_CHK;
      end
      uemr_pkg::UEMR_M_STALL_IO: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_STALL;
        d.out_act  = uemr_pkg::UEMR_OUT_STALL;
      end
      uemr_pkg::UEMR_M_IGN_IO: d.setup_ok = 1'b1;
      uemr_pkg::UEMR_M_STAT_IN: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_TX0;
        d.out_act  = uemr_pkg::UEMR_OUT_STALL;
        d.out_nx   = uemr_pkg::UEMR_M_STALL_IO;
      end
      uemr_pkg::UEMR_M_RSV7: d.in_act = uemr_pkg::UEMR_IN_TXC;
      uemr_pkg::UEMR_M_NAK_OUT: d.out_act = uemr_pkg::UEMR_OUT_NAK;
      uemr_pkg::UEMR_M_ACK_OUT: begin
        d.out_act = d.stall_sel ? uemr_pkg::UEMR_OUT_STALL
                                : uemr_pkg::UEMR_OUT_ACK;
        d.out_nx  = d.stall_sel ? d.mode : uemr_pkg::UEMR_M_NAK_OUT;
      end
      uemr_pkg::UEMR_M_NAKOUT_STIN: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_TX0;
        d.out_act  = uemr_pkg::UEMR_OUT_NAK;
      end
      uemr_pkg::UEMR_M_ACKOUT_NAKIN: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_NAK;
        d.out_act  = uemr_pkg::UEMR_OUT_ACK;
        d.out_nx   = uemr_pkg::UEMR_M_NAK_IO;
      end
      uemr_pkg::UEMR_M_NAK_IN: d.in_act = uemr_pkg::UEMR_IN_NAK;
      uemr_pkg::UEMR_M_ACK_IN: begin
        d.in_act = d.stall_sel ? uemr_pkg::UEMR_IN_STALL
                               : uemr_pkg::UEMR_IN_TXC;
        d.in_nx  = uemr_pkg::UEMR_M_NAK_IN;
      end
      uemr_pkg::UEMR_M_NAKIN_STOUT: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_NAK;
        d.out_act  = uemr_pkg::UEMR_OUT_CHK;
      end
      uemr_pkg::UEMR_M_ACKIN_STOUT: begin
        d.setup_ok = 1'b1;
        d.in_act   = uemr_pkg::UEMR_IN_TXC;
        d.out_act  = uemr_pkg::UEMR_OUT_CHK;
        d.in_nx    = uemr_pkg::UEMR_M_NAKIN_STOUT;
        d.out_nx   = uemr_pkg::UEMR_M_NAKIN_STOUT;
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

//--- hw/uemr_top.sv
// endpoint mode responder of the serial interface engine, ahb-lite regs
//
// What this block does
// R1: status-check OUT gets ACK only with zero data bytes and toggle one.
// R2: failing status-check OUT gets STALL, or silence when the packet is bad.
// R3: counted-transmit IN sends as many bytes as the endpoint count field.
// R4: zero-byte transmit IN sends an empty data packet.
// R5: an ignored token gets no handshake at all.
// R6: setup-accepting modes ACK every valid SETUP.
// R7: ack-in status-out mode moves to nak-in status-out after ACKed OUT.
// R8: valid SETUP on accepting endpoint moves mode to NAK both ways.
// R9: reset disables all endpoints; disabled ones stay silent until rewritten.
// R10: firmware keeps non-control endpoints out of setup-accepting modes.
// R11: only valid transactions are answered; invalid ones get no handshake.
// R12: interrupt on completed valid transaction and on buffer corruption.
// R13: corruption is an OUT or SETUP data packet ending with bad CRC.
// R14: data packet valid only if count with CRC within size plus two.
// R15: OUT endpoints ignore IN tokens, IN endpoints ignore OUT tokens.
// R16: IN and OUT flags set at end, SETUP flag at data start.
// R17: ACKed endpoint-zero transaction locks its mode and count registers.
// R18: lock clears only on a CPU read of them after the transaction.
// R19: valid short SETUP stores count, toggle, sets flags, ACKs, interrupts.
// R20: long or bad-CRC data is junk, no handshake, still interrupts.
// R21: ack-out nak-in mode: valid OUT sets flags, ACKs, interrupts.
// R22: ACKed OUT in ack-out nak-in mode moves mode to NAK both ways.
// R23: modes are four bits; stall select turns ack-out and ack-in modes into STALL on non-control endpoints.
// R24: firmware mode writes land only while the endpoint lock is clear.
`timescale 1ns/1ps
`default_nettype none
module uemr_top #(
  parameter int NUM_EP  = uemr_pkg::UEMR_DEF_NUM_EP,
  parameter int EP_SIZE = uemr_pkg::UEMR_DEF_EP_SIZE
) (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  input  wire  logic        tok_stb,
  input  wire  logic [1:0]  tok_pid,
  input  wire  logic [1:0]  tok_ep,
  input  wire  logic        pkt_start,
  input  wire  logic        pkt_stb,
  input  wire  logic [4:0]  pkt_cnt,
  input  wire  logic        pkt_crc_ok,
  input  wire  logic        pkt_err_ok,
  input  wire  logic        pkt_tog,
  input  wire  logic        hs_ack,
  input  wire  logic        hs_none,
  output var   logic        resp_stb,
  output var   uemr_pkg::uemr_resp_t resp_kind,
  output var   logic [3:0]  resp_len,
  output var   logic [NUM_EP-1:0] ep_int,
  output var   logic        ep0_lock
);
  localparam logic [4:0] MAX_PKT = 5'(EP_SIZE + 2);

  typedef enum logic [1:0] {UEMR_S_IDLE, UEMR_S_DATA, UEMR_S_HACK}
    uemr_state_t;
  uemr_state_t state;

  logic [3:0] mode     [NUM_EP];
  logic       stall    [NUM_EP];
  logic       f_setup  [NUM_EP];
  logic       f_in     [NUM_EP];
  logic       f_out    [NUM_EP];
  logic       f_ack    [NUM_EP];
  logic [3:0] cnt      [NUM_EP];
  logic       dval     [NUM_EP];
  logic       tog      [NUM_EP];
  logic [1:0] cur_ep;
  logic [1:0] cur_pid;

  // ahb data phase state
  logic       dp_wr;
  logic       dp_region;
  logic [1:0] dp_idx;

  uemr_dec_if dif ();
  uemr_mode_dec u_dec (.d(dif.dec));

  wire logic [1:0] sel_ep   = (state == UEMR_S_IDLE) ? tok_ep : cur_ep;
  wire logic       sel_ok   = 32'(sel_ep) < NUM_EP;
  assign dif.mode      = sel_ok ? mode[sel_ep] : uemr_pkg::UEMR_M_DIS;
  // the stall selector exists only on non-control endpoints
  assign dif.stall_sel = sel_ok && sel_ep != 2'h0 && stall[sel_ep]; // [R23]

  // packet qualification
  wire logic pkt_long = pkt_cnt > MAX_PKT;
  wire logic pkt_bad  = !(pkt_crc_ok && pkt_err_ok);
  wire logic pkt_good = !pkt_long && !pkt_bad; // [R14]
  wire logic [4:0] data_len = pkt_cnt - uemr_pkg::UEMR_CRC_LEN;
  wire logic chk_pass = pkt_cnt == uemr_pkg::UEMR_CHK_CNT &&
                        pkt_tog == uemr_pkg::UEMR_CHK_TOG;

  wire logic idle_tok  = state == UEMR_S_IDLE && tok_stb && sel_ok;
  wire logic in_tok    = idle_tok && tok_pid == uemr_pkg::UEMR_PID_IN;
  wire logic dat_tok   = idle_tok && tok_pid != uemr_pkg::UEMR_PID_IN;
  wire logic data_end  = state == UEMR_S_DATA && pkt_stb;
  wire logic is_setup  = cur_pid == uemr_pkg::UEMR_PID_SETUP;
  wire logic setup_end = data_end && is_setup && dif.setup_ok;
  wire logic out_end   = data_end && cur_pid == uemr_pkg::UEMR_PID_OUT;
  wire logic out_acc   = out_end && dif.out_act == uemr_pkg::UEMR_OUT_ACK;
  wire logic out_chk   = out_end && dif.out_act == uemr_pkg::UEMR_OUT_CHK;
  wire logic out_hs    = out_end && pkt_good &&
                         (dif.out_act == uemr_pkg::UEMR_OUT_NAK ||
                          dif.out_act == uemr_pkg::UEMR_OUT_STALL);
  // data-taking transactions record toggle and count even when junk
  wire logic takes_data = setup_end || out_acc;
  wire logic take_ok    = takes_data && pkt_good;
  wire logic chk_ok     = out_chk && pkt_good;
  wire logic ack_out    = take_ok || (chk_ok && chk_pass);
  wire logic in_end_ack = state == UEMR_S_HACK && hs_ack;
  wire logic in_end_no  = state == UEMR_S_HACK && hs_none;
  wire logic lock_set   = cur_ep == 2'h0 &&
                          (ack_out || in_end_ack); // [R17]

  // ahb address phase decode
  wire logic a_valid  = hsel && hready && htrans[1];
  wire logic [1:0] a_idx = haddr[3:2];
  wire logic a_map    = haddr[31:5] == 27'h0 && 32'(a_idx) < NUM_EP;
  wire logic a_region = haddr[uemr_pkg::UEMR_REGION_BIT];
  wire logic a_rd     = a_valid && !hwrite && a_map;
  wire logic a_wr     = a_valid && hwrite && a_map;
  // reading either locked register after the transaction frees the lock
  wire logic lock_clr = a_rd && a_idx == 2'h0 &&
                        state == UEMR_S_IDLE; // [R18]
  wire logic cpu_wr   = dp_wr && !(dp_idx == 2'h0 && ep0_lock); // [R24]

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (a_rd && !a_region) begin
      rd_word[3:0] = mode[a_idx];
      rd_word[uemr_pkg::UEMR_F_ACK] = f_ack[a_idx];
      rd_word[uemr_pkg::UEMR_F_OUT] = f_out[a_idx];
      rd_word[uemr_pkg::UEMR_F_IN]  = f_in[a_idx];
      rd_word[uemr_pkg::UEMR_F_SETUP] = (a_idx == 2'h0) ? f_setup[0]
                                                        : stall[a_idx];
    end else if (a_rd) begin
      rd_word[3:0] = cnt[a_idx];
      rd_word[uemr_pkg::UEMR_F_DVAL] = dval[a_idx];
      rd_word[uemr_pkg::UEMR_F_TOG]  = tog[a_idx];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      dp_wr     <= 1'b0;
      dp_region <= 1'b0;
      dp_idx    <= 2'h0;
      ep0_lock  <= 1'b0;
    end else begin
      hrdata    <= rd_word;
      hreadyout <= 1'b1;
      dp_wr     <= a_wr;
      dp_region <= a_region;
      dp_idx    <= a_idx;
      // a new lock wins over a read in the same cycle
      if (lock_set)
        ep0_lock <= 1'b1;
      else if (lock_clr)
        ep0_lock <= 1'b0;
    end
  end

  // transaction sequencing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state   <= UEMR_S_IDLE;
      cur_ep  <= 2'h0;
      cur_pid <= uemr_pkg::UEMR_PID_OUT;
    end else begin
      case (state)
        UEMR_S_IDLE: begin
          if (idle_tok) begin
            cur_ep  <= tok_ep;
            cur_pid <= tok_pid;
          end
          if (dat_tok)
            state <= UEMR_S_DATA;
          else if (in_tok && (dif.in_act == uemr_pkg::UEMR_IN_TX0 ||
                              dif.in_act == uemr_pkg::UEMR_IN_TXC))
            state <= UEMR_S_HACK;
        end
        // a fresh token aborts a transaction whose end never came
        UEMR_S_DATA: if (pkt_stb || tok_stb) state <= UEMR_S_IDLE;
        UEMR_S_HACK: if (hs_ack || hs_none || tok_stb)
          state <= UEMR_S_IDLE;
        default: state <= UEMR_S_IDLE;
      endcase
    end
  end

  // answers to the host; silence is simply no strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_stb  <= 1'b0;
      resp_kind <= uemr_pkg::UEMR_R_NONE;
      resp_len  <= 4'h0;
      ep_int    <= '0;
    end else begin
      resp_stb  <= 1'b0;
      resp_kind <= uemr_pkg::UEMR_R_NONE;
      resp_len  <= 4'h0;
      ep_int    <= '0;
      if (in_tok) begin
        case (dif.in_act) // [R15]
          uemr_pkg::UEMR_IN_NAK: begin
            resp_stb  <= 1'b1;
            resp_kind <= uemr_pkg::UEMR_R_NAK;
            ep_int[tok_ep] <= 1'b1;
          end
          uemr_pkg::UEMR_IN_STALL: begin
            resp_stb  <= 1'b1;
            resp_kind <= uemr_pkg::UEMR_R_STALL;
            ep_int[tok_ep] <= 1'b1;
          end
          uemr_pkg::UEMR_IN_TX0: begin
            resp_stb  <= 1'b1; // [R4]
            resp_kind <= uemr_pkg::UEMR_R_DATA;
          end
          uemr_pkg::UEMR_IN_TXC: begin
            resp_stb  <= 1'b1;
            resp_kind <= uemr_pkg::UEMR_R_DATA;
            resp_len  <= cnt[tok_ep]; // [R3]
          end
          default: ; // [R5]
        endcase
      end
      if (in_end_ack || in_end_no)
        ep_int[cur_ep] <= 1'b1; // [R12]
      if (ack_out) begin
        resp_stb  <= 1'b1; // [R6] [R1]
        resp_kind <= uemr_pkg::UEMR_R_ACK;
      end else if ((chk_ok && !chk_pass) ||
                   (out_hs && dif.out_act == uemr_pkg::UEMR_OUT_STALL)) begin
        resp_stb  <= 1'b1; // [R2]
        resp_kind <= uemr_pkg::UEMR_R_STALL;
      end else if (out_hs) begin
        resp_stb  <= 1'b1;
        resp_kind <= uemr_pkg::UEMR_R_NAK;
      end
      // junk data still interrupts; bad packets elsewhere stay silent
      if (takes_data || chk_ok || out_hs)
        ep_int[cur_ep] <= 1'b1; // [R12] [R20] [R11]
    end
  end

  // endpoint state: cpu writes first, engine updates override
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) begin
        mode[i]    <= uemr_pkg::UEMR_M_DIS; // [R9]
        stall[i]   <= 1'b0;
        f_setup[i] <= 1'b0;
        f_in[i]    <= 1'b0;
        f_out[i]   <= 1'b0;
        f_ack[i]   <= 1'b0;
        cnt[i]     <= 4'h0;
        dval[i]    <= 1'b0;
        tog[i]     <= 1'b0;
      end
    end else begin
      if (cpu_wr && !dp_region) begin
        mode[dp_idx]    <= hwdata[3:0];
        f_ack[dp_idx]   <= hwdata[uemr_pkg::UEMR_F_ACK];
        f_out[dp_idx]   <= hwdata[uemr_pkg::UEMR_F_OUT];
        f_in[dp_idx]    <= hwdata[uemr_pkg::UEMR_F_IN];
        if (dp_idx == 2'h0)
          f_setup[0]    <= hwdata[uemr_pkg::UEMR_F_SETUP];
        else
          stall[dp_idx] <= hwdata[uemr_pkg::UEMR_F_STALL]; // [R23]
      end else if (cpu_wr) begin
        cnt[dp_idx] <= hwdata[3:0];
        tog[dp_idx] <= hwdata[uemr_pkg::UEMR_F_TOG];
      end
      if (state == UEMR_S_DATA && pkt_start && is_setup && dif.setup_ok)
        f_setup[cur_ep] <= 1'b1; // [R16]
      if (takes_data || chk_ok) begin
        tog[cur_ep] <= pkt_tog;
        cnt[cur_ep] <= data_len[3:0];
      end
      if (takes_data && pkt_bad)
        dval[cur_ep] <= 1'b0; // [R13] [R20]
      else if (take_ok || chk_ok)
        dval[cur_ep] <= 1'b1; // [R19]
      if (out_acc || chk_ok || out_hs)
        f_out[cur_ep] <= 1'b1; // [R16] [R21]
      if (ack_out || in_end_ack)
        f_ack[cur_ep] <= 1'b1;
      if (in_end_ack || in_end_no || (in_tok &&
          (dif.in_act == uemr_pkg::UEMR_IN_NAK ||
           dif.in_act == uemr_pkg::UEMR_IN_STALL)))
        f_in[in_tok ? tok_ep : cur_ep] <= 1'b1;
      if (setup_end && pkt_good)
        mode[cur_ep] <= uemr_pkg::UEMR_M_NAK_IO; // [R8]
      else if (ack_out || out_hs)
        mode[cur_ep] <= dif.out_nx; // [R7] [R22]
      else if (chk_ok)
        mode[cur_ep] <= uemr_pkg::UEMR_M_STALL_IO; // [R2]
      if (in_end_ack)
        mode[cur_ep] <= dif.in_nx;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_chk_ack;
    chk_ok && chk_pass |=> resp_stb && resp_kind == uemr_pkg::UEMR_R_ACK;
  endproperty
  a_chk_ack: assert property (p_chk_ack) // [R1]
    else $error("status OUT with good data not ACKed");

  property p_chk_fail;
    chk_ok && !chk_pass |=> resp_stb && resp_kind == uemr_pkg::UEMR_R_STALL
                            && mode[cur_ep] == uemr_pkg::UEMR_M_STALL_IO;
  endproperty
  a_chk_fail: assert property (p_chk_fail) // [R2]
    else $error("failed status OUT not stalled");

  property p_txc;
    in_tok && dif.in_act == uemr_pkg::UEMR_IN_TXC |=> resp_stb &&
      resp_kind == uemr_pkg::UEMR_R_DATA && resp_len == $past(cnt[tok_ep]);
  endproperty
  a_txc: assert property (p_txc) // [R3]
    else $error("counted IN length wrong");

  property p_tx0;
    in_tok && dif.in_act == uemr_pkg::UEMR_IN_TX0 |=>
      resp_stb && resp_kind == uemr_pkg::UEMR_R_DATA && resp_len == 4'h0;
  endproperty
  a_tx0: assert property (p_tx0) // [R4]
    else $error("zero byte IN not sent");

  property p_silent;
    (in_tok && dif.in_act == uemr_pkg::UEMR_IN_IGN) ||
    (out_end && dif.out_act == uemr_pkg::UEMR_OUT_IGN) |=> !resp_stb;
  endproperty
  a_silent: assert property (p_silent) // [R5]
    else $error("handshake sent for ignored token");

  property p_setup;
    setup_end && pkt_good |=> resp_stb && resp_kind == uemr_pkg::UEMR_R_ACK &&
      mode[$past(cur_ep)] == uemr_pkg::UEMR_M_NAK_IO && ep_int != '0;
  endproperty
  a_setup: assert property (p_setup) // [R8]
    else $error("valid SETUP not ACKed into NAK mode");

  property p_bad_quiet;
    data_end && !pkt_good |=> !resp_stb;
  endproperty
  a_bad_quiet: assert property (p_bad_quiet) // [R11]
    else $error("invalid packet answered");

  property p_lock;
    lock_set |=> ep0_lock ##1 (ep0_lock || $past(lock_clr));
  endproperty
  a_lock: assert property (p_lock) // [R17]
    else $error("endpoint zero lock not held");
endmodule
`default_nettype wire

//--- tb/uemr_host_model.sv
// behavioural usb host that sends tokens, data packets and handshakes
`timescale 1ns/1ps
`default_nettype none
module uemr_host_model (
  input  wire logic       mclk,
  output var  logic       tok_stb,
  output var  logic [1:0] tok_pid,
  output var  logic [1:0] tok_ep,
  output var  logic       pkt_start,
  output var  logic       pkt_stb,
  output var  logic [4:0] pkt_cnt,
  output var  logic       pkt_crc_ok,
  output var  logic       pkt_err_ok,
  output var  logic       pkt_tog,
  output var  logic       hs_ack,
  output var  logic       hs_none
);
  // extra idle cycles before the host hands back its handshake
  int slow = 0;
  initial begin
    {tok_stb, tok_pid, tok_ep, pkt_start, pkt_stb} = '0;
    {pkt_cnt, pkt_crc_ok, pkt_err_ok, pkt_tog, hs_ack, hs_none} = '0;
  end
  task automatic token(input logic [1:0] pid, input logic [1:0] ep);
    @(posedge mclk);
    {tok_stb, tok_pid, tok_ep} <= {1'h1, pid, ep};
    @(posedge mclk);
    {tok_stb, tok_pid, tok_ep} <= {1'h0, ~pid, ~ep};
  endtask
  // count carries the two crc bytes; qualifiers flip after the strobe
  task automatic packet(input logic [4:0] cnt, input logic [2:0] q);
    @(posedge mclk);
    pkt_start <= 1'h1;
    @(posedge mclk);
    pkt_start <= 1'h0;
    @(posedge mclk);
    {pkt_stb, pkt_cnt, pkt_crc_ok, pkt_err_ok, pkt_tog} <= {1'h1, cnt, q};
    @(posedge mclk);
    {pkt_stb, pkt_cnt, pkt_crc_ok, pkt_err_ok, pkt_tog} <= {1'h0, ~cnt, ~q};
  endtask
  task automatic hshake(input logic ack);
    repeat (slow + 1) @(posedge mclk);
    {hs_ack, hs_none} <= {ack, ~ack};
    @(posedge mclk);
    {hs_ack, hs_none} <= 2'h0;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench: ahb-lite register access plus host token traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  logic [1:0]           htrans, tok_pid, tok_ep;
  logic [2:0]           hsize, ep_int;
  logic [4:0]           pkt_cnt;
  logic [3:0]           resp_len, got_len;
  logic                 tok_stb, pkt_start, pkt_stb, pkt_crc_ok, pkt_err_ok;
  logic                 pkt_tog, hs_ack, hs_none, resp_stb, ep0_lock;
  uemr_pkg::uemr_resp_t resp_kind, got_kind;
  int                   mismatches = 0, checks = 0;
  int                   resp_n = 0, int_n = 0, cyc = 0;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  localparam logic [1:0] P_OUT = uemr_pkg::UEMR_PID_OUT;
  localparam logic [1:0] P_IN  = uemr_pkg::UEMR_PID_IN;
  localparam logic [1:0] P_SU  = uemr_pkg::UEMR_PID_SETUP;
  localparam uemr_pkg::uemr_resp_t R_NO  = uemr_pkg::UEMR_R_NONE;
  localparam uemr_pkg::uemr_resp_t R_ACK = uemr_pkg::UEMR_R_ACK;
  localparam uemr_pkg::uemr_resp_t R_STL = uemr_pkg::UEMR_R_STALL;
  localparam uemr_pkg::uemr_resp_t R_DAT = uemr_pkg::UEMR_R_DATA;
  uemr_top #(.NUM_EP(3), .EP_SIZE(8)) dut (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .tok_stb, .tok_pid, .tok_ep, .pkt_start,
    .pkt_stb, .pkt_cnt, .pkt_crc_ok, .pkt_err_ok, .pkt_tog, .hs_ack,
    .hs_none, .resp_stb, .resp_kind, .resp_len, .ep_int, .ep0_lock
  );
  uemr_host_model host (
    .mclk, .tok_stb, .tok_pid, .tok_ep, .pkt_start, .pkt_stb, .pkt_cnt,
    .pkt_crc_ok, .pkt_err_ok, .pkt_tog, .hs_ack, .hs_none
  );
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (resp_stb === 1'h1) begin
      resp_n <= resp_n + 1;
      got_kind <= resp_kind;
      got_len <= resp_len;
    end
    if (|ep_int) int_n <= int_n + 1;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    {hsel, haddr, htrans, hwrite, hsize} <= {1'h1, a, 2'h2, w, 3'h2};
    do @(posedge mclk); while (hready !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    do @(posedge mclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, e);
    ahb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // q packs crc ok, other checks ok, toggle, host ack
  task automatic xfer(input logic [1:0] pid, input logic [1:0] ep,
                      input logic [4:0] cnt, input logic [3:0] q,
                      input uemr_pkg::uemr_resp_t k, input logic [3:0] len,
                      input int ni);
    int n0, i0;
    n0 = resp_n;
    i0 = int_n;
    host.token(pid, ep);
    if (pid != uemr_pkg::UEMR_PID_IN) host.packet(cnt, q[3:1]);
    repeat (3) @(posedge mclk);
    if (k == uemr_pkg::UEMR_R_DATA) host.hshake(q[0]);
    repeat (3) @(posedge mclk);
    chk("resp_count", (k == uemr_pkg::UEMR_R_NONE) ? 0 : 1, resp_n - n0);
    if (k != uemr_pkg::UEMR_R_NONE) chk("resp_kind", k, got_kind);
    if (k == uemr_pkg::UEMR_R_DATA) chk("resp_len", len, got_len);
    chk("int_count", ni, int_n - i0);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 3; i++) rdchk("mode", 32'(4 * i), 32'h0);
    rdchk("unmapped", 32'h40, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    xfer(P_IN, 0, 0, 4'hF, R_NO, 0, 0);
    xfer(P_OUT, 1, 4, 4'hF, R_NO, 0, 0);
    done("reset");
    ahb(1'h1, 32'h0, 32'h4);
    xfer(P_SU, 0, 10, 4'hC, R_ACK, 0, 1);
    chk("lock", 32'h1, {31'h0, ep0_lock});
    ahb(1'h1, 32'h0, 32'h0B);
    rdchk("mode", 32'h0, 32'h91);
    rdchk("count", 32'h10, 32'h48);
    chk("lock", 32'h0, {31'h0, ep0_lock});
    done("setup");
    ahb(1'h1, 32'h0, 32'h0B);
    xfer(P_OUT, 0, 11, 4'hE, R_NO, 0, 1);
    xfer(P_OUT, 0, 4, 4'h6, R_NO, 0, 1);
    rdchk("count", 32'h10, 32'h82);
    xfer(P_OUT, 0, 4, 4'hC, R_ACK, 0, 1);
    rdchk("mode", 32'h0, 32'h31);
    xfer(P_OUT, 0, 4, 4'hA, R_NO, 0, 0);
    done("control");
    ahb(1'h1, 32'h10, 32'h03);
    ahb(1'h1, 32'h0, 32'h0F);
    xfer(P_IN, 0, 0, 4'h1, R_DAT, 3, 1);
    rdchk("mode", 32'h0, 32'h5E);
    ahb(1'h1, 32'h0, 32'h0F);
    xfer(P_OUT, 0, 2, 4'hE, R_ACK, 0, 1);
    rdchk("mode", 32'h0, 32'h3E);
    xfer(P_OUT, 0, 2, 4'hC, R_STL, 0, 1);
    rdchk("mode", 32'h0, 32'h33);
    done("status");
    ahb(1'h1, 32'h0, 32'h0A);
    host.slow = 3;
    xfer(P_IN, 0, 0, 4'h0, R_DAT, 0, 1);
    host.slow = 0;
    ahb(1'h1, 32'h0, 32'h02);
    xfer(P_OUT, 0, 2, 4'hE, R_ACK, 0, 1);
    rdchk("mode", 32'h0, 32'h32);
    done("zero");
    ahb(1'h1, 32'h4, 32'h09);
    xfer(P_IN, 1, 0, 4'h1, R_NO, 0, 0);
    xfer(P_OUT, 1, 4, 4'hC, R_ACK, 0, 1);
    rdchk("mode", 32'h4, 32'h38);
    ahb(1'h1, 32'h4, 32'h8D);
    xfer(P_IN, 1, 0, 4'h1, R_STL, 0, 1);
    done("endpoint");
    tally_and_finish;
  end
endmodule
`default_nettype wire
